/* src/dccm_pkg.sv */
// constants and types shared by the debug comms channel and monitor block
package dccm_pkg;
  // coprocessor register numbers
  localparam logic [3:0] CREG_STATUS = 4'h0;
  localparam logic [3:0] CREG_DATA = 4'h1;
  localparam logic [3:0] CREG_ABORT = 4'h2;
  // status word, abort origin and debug control field positions and widths
  localparam int STAT_IN_BIT = 0;
  localparam int STAT_OUT_BIT = 1;
  localparam int STAT_VER_LSB = 28;
  localparam int ABORT_ORIGIN_BIT = 0;
  localparam int DBG_CTRL_MONITOR_BIT = 4;
  localparam int DBG_CTRL_W = 6;
  // fixed version field, value arbitrary
  localparam logic [3:0] VERSION_FIELD = 4'h1;
  // reset values
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic ABORT_ORIGIN_RESET = 1'b0;
  localparam logic [DBG_CTRL_W-1:0] DBG_CTRL_RESET = 6'h00;
  // link-side transaction codes
  typedef enum logic [1:0] {
    DCCM_LNK_IDLE,
    DCCM_LNK_RD_STATUS,
    DCCM_LNK_RD_OUT,
    DCCM_LNK_WR_IN
  } dccm_lnk_op_t;
endpackage : dccm_pkg

/* src/dccm_xfer_if.sv */
// event crossing carrier between core and link domains
interface dccm_xfer_if;
  logic src_pulse;
  logic dst_pulse;
  modport src (input src_pulse);
  modport dst (output dst_pulse);
endinterface : dccm_xfer_if

/* src/dccm_pulse_sync.sv */
// toggle-based event crossing from one clock domain to another
module dccm_pulse_sync (
  input wire logic src_clk,
  input wire logic dst_clk,
  input wire logic rst,
  dccm_xfer_if x
);
  logic tog_reg;
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // source toggles once per event
  always_ff @(posedge src_clk or posedge rst) begin
    if (rst) begin
      tog_reg <= 1'b0;
    end else if (x.src_pulse) begin
      tog_reg <= ~tog_reg;
    end
  end

  // two-flop synchroniser then edge register
  always_ff @(posedge dst_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= tog_reg;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign x.dst_pulse = s2_reg ^ s3_reg;
endmodule : dccm_pulse_sync

/* src/dccm_top.sv */
// debug comms channel mailbox, abort origin and monitor-mode match gating
// Summary of operation
// RULE1 - abort status register keeps one bit at 0, others read zero
// RULE2 - abort origin one means prefetch abort, zero means data abort
// RULE3 - prefetch abort from a debug match sets the origin bit
// RULE4 - external abort on same access wins, origin bit left unchanged
// RULE5 - every monitor-mode abort is recorded in the abort status register; code records only the prefetch abort when both come in one cycle
// RULE6 - software polls outbound flag and writes only once it is clear
// RULE7 - core write of outbound data sets the outbound flag
// RULE8 - both flags visible to debugger through the scan chain status
// RULE9 - debugger read of outbound data clears the outbound flag
// RULE10 - debugger writes inbound data only while inbound flag is clear
// RULE11 - debugger write of inbound data sets the inbound flag
// RULE12 - core read of inbound data clears the inbound flag
// RULE13 - control bit 4 selects monitor mode, matches become aborts
// RULE14 - monitor mode ignores data conditions, range and chaining
// RULE15 - monitor matches qualify only on address, qualifier, privilege, direction, size
// RULE16 - monitor mode disables single-step and external break or watch inputs
// RULE17 - vector catch must not target prefetch or data abort
// RULE18 - no halt request while monitor mode is selected
// RULE19 - watch unit match suppressed in cycle its register is written; code suppresses it only while mem_access_active is also set
// RULE20 - debugger disables unit, reprograms, then re-enables it
// RULE21 - status read-only: inbound bit 0, outbound bit 1, version 31:28
// RULE22 - data registers 32 bits, shared data number, status at another
// RULE23 - reset clears both flags and the abort origin bit
module dccm_top (
  input wire logic clk,
  input wire logic rst,
  // coprocessor transfer port, core clock
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [3:0] cp_reg,
  input wire logic [31:0] cp_wdata,
  output logic [31:0] cp_rdata,
  output logic cp_rvalid,
  // debug control from the scan chain, core clock domain image
  input wire logic [5:0] debug_ctrl_in,
  input wire logic debug_ctrl_we,
  // raw watch unit matches and qualifiers
  input wire logic bkpt_addr_match,
  input wire logic wpt_addr_match,
  input wire logic bkpt_data_cond,
  input wire logic wpt_data_cond,
  input wire logic bkpt_range_chain,
  input wire logic wpt_range_chain,
  input wire logic bkpt_unit_reg_we,
  input wire logic wpt_unit_reg_we,
  input wire logic mem_access_active,
  input wire logic external_watch_qualifier,
  input wire logic fetch_privilege_flag,
  input wire logic data_privilege_flag,
  input wire logic fetch_width_flag,
  input wire logic [1:0] data_access_size,
  input wire logic qual_ok,
  input wire logic ext_breakpoint,
  input wire logic ext_watchpoint,
  input wire logic single_step_req,
  input wire logic external_abort,
  // link side, scan chain clock
  input wire logic tck,
  input wire logic lnk_valid,
  input wire logic [1:0] lnk_op,
  input wire logic [31:0] lnk_wdata,
  output logic [31:0] lnk_rdata,
  // core outputs
  output logic prefetch_abort,
  output logic data_abort,
  output logic halt_request,
  output logic single_step_en,
  output logic monitor_mode
);
  logic [31:0] out_data_reg;
  logic [31:0] in_data_reg;
  logic out_flag_reg;
  logic in_flag_reg;
  logic abort_origin_reg;
  logic [5:0] dbg_ctrl_reg;
  logic [31:0] cp_rdata_reg;
  logic cp_rvalid_reg;
  logic pabt_reg;
  logic dabt_reg;
  logic halt_reg;
  logic step_reg;
  logic [31:0] lnk_rdata_reg;
  logic [31:0] in_stage_reg;
  logic out_ack_core;
  logic in_wr_core;
  logic out_flag_s1_reg;
  logic out_flag_s2_reg;
  logic in_flag_s1_reg;
  logic in_flag_s2_reg;
  logic [31:0] out_data_s1_reg;
  logic [31:0] out_data_link_reg;
  logic mon;
  logic cp_wr_out;
  logic cp_rd_in;
  logic cp_wr_abt;
  logic lnk_rd_out;
  logic lnk_rd_stat;
  logic lnk_wr_in;
  logic bkpt_hit;
  logic wpt_hit;
  logic pabt_take;
  logic dabt_take;
  dccm_xfer_if x_out_ack ();
  dccm_xfer_if x_in_wr ();

  // word with a single low bit and zero above
  function automatic logic [31:0] low_bit_word(input logic b);
    low_bit_word = {31'h0000_0000, b};
  endfunction

  // channel status word as seen from either side
  function automatic logic [31:0] status_word(input logic out_f, input logic in_f);
    status_word = {dccm_pkg::VERSION_FIELD, 26'h000_0000, out_f, in_f}; // RULE21
  endfunction

  // coprocessor transfer decode for one direction and register number
  function automatic logic cp_sel(
    input logic v,
    input logic w,
    input logic [3:0] rn,
    input logic want_w,
    input logic [3:0] want_rn
  );
    cp_sel = v && (w == want_w) && (rn == want_rn);
  endfunction

  // link operation decode
  function automatic logic lnk_sel(
    input logic v,
    input logic [1:0] op,
    input dccm_pkg::dccm_lnk_op_t want
  );
    lnk_sel = v && (op == 2'(want));
  endfunction

  // watch unit match usable in monitor mode, no data, range or chain terms
  function automatic logic unit_hit(
    input logic addr_match,
    input logic data_cond,
    input logic range_chain,
    input logic reg_we,
    input logic mem_active,
    input logic ok
  );
    unit_hit = addr_match && ok && !data_cond && !range_chain // RULE14 RULE15
      && !(reg_we && mem_active); // RULE19
  endfunction

  assign mon = dbg_ctrl_reg[dccm_pkg::DBG_CTRL_MONITOR_BIT]; // RULE13
  assign cp_wr_out = cp_sel(cp_valid, cp_write, cp_reg, 1'b1, dccm_pkg::CREG_DATA); // RULE7
  assign cp_rd_in = cp_sel(cp_valid, cp_write, cp_reg, 1'b0, dccm_pkg::CREG_DATA); // RULE22
  assign cp_wr_abt = cp_sel(cp_valid, cp_write, cp_reg, 1'b1, dccm_pkg::CREG_ABORT); // RULE1
  assign lnk_rd_stat = lnk_sel(lnk_valid, lnk_op, dccm_pkg::DCCM_LNK_RD_STATUS); // RULE8
  assign lnk_rd_out = lnk_sel(lnk_valid, lnk_op, dccm_pkg::DCCM_LNK_RD_OUT);
  assign lnk_wr_in = lnk_sel(lnk_valid, lnk_op, dccm_pkg::DCCM_LNK_WR_IN);

  // monitor match: address plus simple qualifiers only, suppressed on update while mem_access_active is set
  assign bkpt_hit = unit_hit(bkpt_addr_match, bkpt_data_cond, bkpt_range_chain,
    bkpt_unit_reg_we, mem_access_active, qual_ok); // RULE14 RULE19
  assign wpt_hit = unit_hit(wpt_addr_match, wpt_data_cond, wpt_range_chain,
    wpt_unit_reg_we, mem_access_active, qual_ok); // RULE15 RULE19
  assign pabt_take = mon && bkpt_hit && !external_abort; // RULE4
  assign dabt_take = mon && wpt_hit && !external_abort; // RULE4

  // debug control image
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dbg_ctrl_reg <= dccm_pkg::DBG_CTRL_RESET;
    end else if (debug_ctrl_we) begin
      dbg_ctrl_reg <= debug_ctrl_in;
    end
  end

  // outbound mailbox word, written by the core
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_data_reg <= dccm_pkg::DATA_RESET;
    end else if (cp_wr_out) begin
      out_data_reg <= cp_wdata;
    end
  end

  // outbound flag, set wins over a coincident clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_flag_reg <= 1'b0; // RULE23
    end else if (cp_wr_out) begin
      out_flag_reg <= 1'b1; // RULE7
    end else if (out_ack_core) begin
      out_flag_reg <= 1'b0; // RULE9
    end
  end

  // inbound word captured from the stable link staging register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_data_reg <= dccm_pkg::DATA_RESET;
    end else if (in_wr_core) begin
      in_data_reg <= in_stage_reg;
    end
  end

  // inbound flag, set wins over a coincident clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_flag_reg <= 1'b0; // RULE23
    end else if (in_wr_core) begin
      in_flag_reg <= 1'b1; // RULE11
    end else if (cp_rd_in) begin
      in_flag_reg <= 1'b0; // RULE12
    end
  end

  // abort origin bit, hardware set wins over software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      abort_origin_reg <= dccm_pkg::ABORT_ORIGIN_RESET; // RULE23
    end else if (pabt_take) begin
      abort_origin_reg <= 1'b1; // RULE3 RULE5
    end else if (dabt_take) begin
      abort_origin_reg <= 1'b0; // RULE2 RULE5
    end else if (cp_wr_abt) begin
      abort_origin_reg <= cp_wdata[dccm_pkg::ABORT_ORIGIN_BIT]; // RULE1
    end
  end

  // read strobe back to the core, one cycle after the transfer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cp_rvalid_reg <= 1'b0;
    end else begin
      cp_rvalid_reg <= cp_valid && !cp_write;
    end
  end

  // coprocessor read data, held until the next read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cp_rdata_reg <= dccm_pkg::DATA_RESET;
    end else begin
      if (cp_valid && !cp_write) begin
        if (cp_reg == dccm_pkg::CREG_STATUS) begin
          cp_rdata_reg <= status_word(out_flag_reg, in_flag_reg); // RULE21
        end else if (cp_reg == dccm_pkg::CREG_DATA) begin
          cp_rdata_reg <= in_data_reg;
        end else if (cp_reg == dccm_pkg::CREG_ABORT) begin
          cp_rdata_reg <= low_bit_word(abort_origin_reg); // RULE1
        end else begin
          cp_rdata_reg <= dccm_pkg::DATA_RESET;
        end
      end
    end
  end

  // abort strobes to the core, one cycle per taken match
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pabt_reg <= 1'b0;
      dabt_reg <= 1'b0;
    end else begin
      pabt_reg <= pabt_take; // RULE13
      dabt_reg <= dabt_take; // RULE13
    end
  end

  // halt-mode controls, held off while monitor mode is selected
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halt_reg <= 1'b0;
      step_reg <= 1'b0;
    end else begin
      halt_reg <= !mon && (bkpt_hit || wpt_hit || ext_breakpoint || ext_watchpoint); // RULE16
      step_reg <= !mon && single_step_req; // RULE16
    end
  end

  // link domain: two-flop synchronisers for both handshake flags
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      out_flag_s1_reg <= 1'b0;
      out_flag_s2_reg <= 1'b0;
      in_flag_s1_reg <= 1'b0;
      in_flag_s2_reg <= 1'b0;
    end else begin
      out_flag_s1_reg <= out_flag_reg; // RULE8
      out_flag_s2_reg <= out_flag_s1_reg;
      in_flag_s1_reg <= in_flag_reg; // RULE8
      in_flag_s2_reg <= in_flag_s1_reg;
    end
  end

  // link domain: outbound word crossed as a bus
  // the core writes it only while the outbound flag is clear, and the
  // debugger reads it only after seeing the flag set, so it is still then
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      out_data_s1_reg <= dccm_pkg::DATA_RESET;
      out_data_link_reg <= dccm_pkg::DATA_RESET;
    end else begin
      out_data_s1_reg <= out_data_reg;
      out_data_link_reg <= out_data_s1_reg;
    end
  end

  // link domain: inbound staging word, still by the time the core takes it
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      in_stage_reg <= dccm_pkg::DATA_RESET;
    end else if (lnk_wr_in) begin
      in_stage_reg <= lnk_wdata; // RULE11
    end
  end

  // link domain: read data to the debugger, held until the next read
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      lnk_rdata_reg <= dccm_pkg::DATA_RESET;
    end else if (lnk_rd_stat) begin
      lnk_rdata_reg <= status_word(out_flag_s2_reg, in_flag_s2_reg); // RULE8
    end else if (lnk_rd_out) begin
      lnk_rdata_reg <= out_data_link_reg; // RULE9
    end
  end

  // event crossings link to core
  assign x_out_ack.src_pulse = lnk_rd_out; // RULE9
  assign x_in_wr.src_pulse = lnk_wr_in; // RULE11
  assign out_ack_core = x_out_ack.dst_pulse;
  assign in_wr_core = x_in_wr.dst_pulse;

  dccm_pulse_sync u_out_ack (
    .src_clk(tck),
    .dst_clk(clk),
    .rst(rst),
    .x(x_out_ack)
  );

  dccm_pulse_sync u_in_wr (
    .src_clk(tck),
    .dst_clk(clk),
    .rst(rst),
    .x(x_in_wr)
  );

  assign cp_rdata = cp_rdata_reg;
  assign cp_rvalid = cp_rvalid_reg;
  assign lnk_rdata = lnk_rdata_reg;
  assign prefetch_abort = pabt_reg;
  assign data_abort = dabt_reg;
  assign halt_request = halt_reg;
  assign single_step_en = step_reg;
  assign monitor_mode = mon;
endmodule : dccm_top

/* tb/dccm_checker.sv */
// port assertions for the comms channel and monitor block
module dccm_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [3:0] cp_reg,
  input wire logic [31:0] cp_rdata,
  input wire logic bkpt_addr_match,
  input wire logic bkpt_data_cond,
  input wire logic bkpt_range_chain,
  input wire logic bkpt_unit_reg_we,
  input wire logic wpt_unit_reg_we,
  input wire logic mem_access_active,
  input wire logic qual_ok,
  input wire logic external_abort,
  input wire logic prefetch_abort,
  input wire logic data_abort,
  input wire logic single_step_en,
  input wire logic monitor_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // status and abort register read images
  property p_stat; cp_valid && !cp_write && cp_reg == 4'h0 |=>
    cp_rdata[31:2] == {dccm_pkg::VERSION_FIELD, 26'h0}; endproperty
  a_stat: assert property (p_stat) else $error("status image");
  property p_abt; cp_valid && !cp_write && cp_reg == 4'h2 |=> cp_rdata[31:1] == 31'h0;
  endproperty
  a_abt: assert property (p_abt) else $error("abort reserved bits");
  // match to abort gating
  property p_pf; monitor_mode && bkpt_addr_match && qual_ok && !bkpt_data_cond &&
    !bkpt_range_chain && !(bkpt_unit_reg_we && mem_access_active) && !external_abort
    |=> prefetch_abort; endproperty
  a_pf: assert property (p_pf) else $error("no prefetch abort");
  property p_mm; !monitor_mode |=> !prefetch_abort && !data_abort; endproperty
  a_mm: assert property (p_mm) else $error("abort outside monitor");
  property p_ext; external_abort |=> !prefetch_abort && !data_abort; endproperty
  a_ext: assert property (p_ext) else $error("abort beside external");
  property p_dc; bkpt_data_cond || bkpt_range_chain |=> !prefetch_abort; endproperty
  a_dc: assert property (p_dc) else $error("data dependent match");
  property p_we; wpt_unit_reg_we && mem_access_active |=> !data_abort; endproperty
  a_we: assert property (p_we) else $error("match during update");
  property p_ss; monitor_mode [*2] |-> !single_step_en; endproperty
  a_ss: assert property (p_ss) else $error("single step in monitor");
endmodule // dccm_checker

bind dccm_top dccm_checker i_dccm_checker (.clk, .rst, .cp_valid, .cp_write, .cp_reg,
  .cp_rdata, .bkpt_addr_match, .bkpt_data_cond, .bkpt_range_chain, .bkpt_unit_reg_we,
  .wpt_unit_reg_we,
  .mem_access_active, .qual_ok, .external_abort, .prefetch_abort, .data_abort,
  .single_step_en, .monitor_mode);

/* tb/dccm_host_model.sv */
// host debugger model on the scan chain side of the mailbox
module dccm_host_model (
  output logic tck,
  output logic lnk_valid,
  output logic [1:0] lnk_op,
  output logic [31:0] lnk_wdata,
  input wire logic [31:0] lnk_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run = 1;
  // link clock runs through reset and within frames only
  initial tck = 0;
  initial #200 run = 0;
  always #7.5 if (run || tck) tck = ~tck;
  initial {lnk_valid, lnk_op, lnk_wdata} = '0;
  // one scan transfer, then idle lines show the inverse word
  task automatic xfer(input logic [1:0] op, input logic [31:0] d, output logic [31:0] q);
    run = 1;
    @(negedge tck);
    {lnk_valid, lnk_op, lnk_wdata} = {1'b1, op, d};
    @(negedge tck);
    {lnk_valid, lnk_op, lnk_wdata} = {1'b0, 2'h0, ~d};
    repeat (8) @(negedge tck);
    q = lnk_rdata;
    run = 0;
  endtask
endmodule // dccm_host_model

/* tb/tb_dccm_top.sv */
// self-checking bench for the comms channel and monitor block
module tb_dccm_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, cp_valid = 0, cp_write = 0, debug_ctrl_we = 0, qual_ok = 1;
  logic [3:0] cp_reg = 4'h0;
  logic [31:0] cp_wdata = 32'h0, cp_rdata, lnk_wdata, lnk_rdata, r;
  logic [5:0] debug_ctrl_in = 6'h00, ql = 6'h00;
  logic [9:0] mv = 10'h000;
  logic [2:0] ex = 3'h0;
  logic [1:0] lnk_op;
  logic cp_rvalid, tck, lnk_valid, prefetch_abort, data_abort, halt_request;
  logic single_step_en, monitor_mode;
  logic [11:0] ce = 12'h83E;
  logic [11:0] pe = 12'h820;
  logic [11:0] de = 12'h401;
  logic [9:0] cv [12] = '{10'h200, 10'h100, 10'h280, 10'h240, 10'h210, 10'h205,
    10'h200, 10'h180, 10'h120, 10'h108, 10'h103, 10'h102};
  int error_cnt = 0, n_tests = 0, cyc = 0;

  dccm_top i_dccm_top (.clk, .rst, .cp_valid, .cp_write, .cp_reg, .cp_wdata, .cp_rdata,
    .cp_rvalid, .debug_ctrl_in, .debug_ctrl_we, .bkpt_addr_match(mv[9]),
    .wpt_addr_match(mv[8]), .external_abort(mv[7]), .bkpt_data_cond(mv[6]),
    .wpt_data_cond(mv[5]), .bkpt_range_chain(mv[4]), .wpt_range_chain(mv[3]),
    .bkpt_unit_reg_we(mv[2]), .wpt_unit_reg_we(mv[1]), .mem_access_active(mv[0]),
    .external_watch_qualifier(ql[5]), .fetch_privilege_flag(ql[4]),
    .data_privilege_flag(ql[3]), .fetch_width_flag(ql[2]), .data_access_size(ql[1:0]),
    .qual_ok, .ext_breakpoint(ex[2]), .ext_watchpoint(ex[1]), .single_step_req(ex[0]),
    .tck, .lnk_valid, .lnk_op, .lnk_wdata, .lnk_rdata, .prefetch_abort, .data_abort,
    .halt_request, .single_step_en, .monitor_mode);
  dccm_host_model i_dccm_host_model (.tck, .lnk_valid, .lnk_op, .lnk_wdata, .lnk_rdata);

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // counts and verdict
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one coprocessor transfer, read word lands in r
  task automatic cp(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(negedge clk);
    {cp_valid, cp_write, cp_reg, cp_wdata} = {1'b1, w, a, d};
    @(negedge clk);
    cp_valid = 0;
    r = 'x;
    repeat (2) begin
      if (cp_rvalid === 1'b1) r = cp_rdata;
      @(negedge clk);
    end
  endtask
  // poll status from host (h) or core until bit b equals v
  task automatic poll(input logic h, input int b, input logic v);
    repeat (40) begin
      if (h) i_dccm_host_model.xfer(2'h1, 32'h0, r);
      else cp(0, 4'h0, 32'h0);
      if (r[b] === v) break;
    end
    chk({31'h0, r[b]}, {31'h0, v});
  endtask

  // core clock and cycle ceiling
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 0;
    cp(0, 4'h0, 32'h0);
    chk(r, 32'h1000_0000);
    cp(0, 4'h2, 32'h0);
    chk(r, 32'h0);
    cp(1, 4'h0, 32'hFFFF_FFFF);
    cp(0, 4'h0, 32'h0);
    chk(r, 32'h1000_0000);
    cp(0, 4'h3, 32'h0);
    chk(r, 32'h0);
    poll(0, 1, 1'b0);
    cp(1, 4'h1, 32'hA5C3_0F96);
    cp(0, 4'h0, 32'h0);
    chk(r, 32'h1000_0002);
    poll(1, 1, 1'b1);
    i_dccm_host_model.xfer(2'h2, 32'h0, r);
    chk(r, 32'hA5C3_0F96);
    poll(0, 1, 1'b0);
    poll(1, 0, 1'b0);
    i_dccm_host_model.xfer(2'h3, 32'h5A3C_F069, r);
    poll(0, 0, 1'b1);
    poll(1, 0, 1'b1);
    cp(0, 4'h1, 32'h0);
    chk(r, 32'h5A3C_F069);
    cp(0, 4'h0, 32'h0);
    chk(r, 32'h1000_0000);
    poll(1, 0, 1'b0);
    cp(1, 4'h2, 32'hFFFF_FFFF);
    cp(0, 4'h2, 32'h0);
    chk(r, 32'h1);
    cp(1, 4'h2, 32'h0);
    cp(0, 4'h2, 32'h0);
    chk(r, 32'h0);
    @(negedge clk);
    {debug_ctrl_in, debug_ctrl_we} = {6'h10, 1'b1};
    @(negedge clk);
    {debug_ctrl_we, ex} = {1'b0, 3'h7};
    chk({31'h0, monitor_mode}, 32'h1);
    for (int i = 0; i < 12; i++) begin
      {mv, ql} = {cv[i], i[5:0]};
      @(negedge clk);
      chk({30'h0, prefetch_abort, data_abort}, {30'h0, pe[11 - i], de[11 - i]});
      mv = 10'h000;
      cp(0, 4'h2, 32'h0);
      chk(r, {31'h0, ce[11 - i]});
      chk({30'h0, halt_request, single_step_en}, 32'h0);
    end
    {mv, qual_ok} = {10'h200, 1'b0};
    @(negedge clk);
    chk({31'h0, prefetch_abort}, 32'h0);
    {mv, qual_ok, debug_ctrl_in, debug_ctrl_we} = {10'h000, 1'b1, 6'h00, 1'b1};
    @(negedge clk);
    {mv, debug_ctrl_we, ex} = {10'h200, 1'b0, 3'h1};
    @(negedge clk);
    {mv, ex} = {10'h000, 3'h0};
    chk({29'h0, halt_request, single_step_en, prefetch_abort}, 32'h6);
    finish_test;
  end
endmodule // tb_dccm_top
